/* File: flow_cmd_exec.sv */
// Executes return, wait, stop, set/get coordinate, jump on timeout and clear error.
// Assumes one command is presented per cmd_valid pulse while cmd_ready is high, and a
// non-volatile store that accepts one entry write per cycle.
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module flow_cmd_exec
    import flow_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire cmd_t cmd,
    input wire logic standalone,
    input wire logic [15:0] pc_in,
    input wire logic [31:0] accu_in,
    input wire axis_t axis,
    input wire logic gp_write,
    input wire logic [7:0] gp_index,
    input wire logic [31:0] gp_value,
    input wire logic [31:0] nv_rdata,
    input wire logic nv_rvalid,
    output logic cmd_ready,
    output logic pc_load,
    output logic [15:0] pc_out,
    output logic hold_pc,
    output logic program_stop,
    output logic accu_load,
    output logic [31:0] accu_out,
    output logic reply_valid,
    output reply_t reply,
    output logic timeout_error_flag,
    output logic nv_we,
    output logic [4:0] nv_addr,
    output logic [31:0] nv_wdata,
    output logic nv_re
);
    typedef enum {S_IDLE, S_WAIT, S_STORE, S_RESTORE, S_RESTORE_RD} state_t;

    state_t state_q;
    logic [31:0] coord_q [NUM_COORDS];
    logic [15:0] stack_q [STACK_DEPTH];
    logic [3:0] sp_q;
    logic [24:0] tick_div_q;
    logic tick_q;
    logic [31:0] wait_left_q;
    logic wait_timed_q;
    logic [7:0] wait_type_q;
    logic store_enable_q;
    logic [4:0] walk_q;
    logic [4:0] walk_end_q;
    logic wait_met;
    logic [31:0] tick_src;
    logic start;

    assign start = cmd_valid && cmd_ready;
    assign tick_src = (cmd.value == VALUE_ACCU) ? accu_in : cmd.value;

    always_comb begin
        unique case (wait_type_q)
            WAIT_POS: wait_met = axis.target_reached;
            WAIT_HOME_SW: wait_met = axis.home_switch;
            WAIT_END_SW: wait_met = axis.end_switch;
            WAIT_HOMING: wait_met = axis.homing_done;
            default: wait_met = 1'b0;
        endcase
    end

    // Free-running tick; a wait may lose up to one tick of phase, as a firmware tick would
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_div_q <= 25'h0;
            tick_q <= 1'b0;
        end else if (tick_div_q == 25'(TICK_CYCLES_P - 1)) begin
            tick_div_q <= 25'h0;
            tick_q <= 1'b1;
        end else begin
            tick_div_q <= tick_div_q + 25'h1;
            tick_q <= 1'b0;
        end
    end

    // Global setting 84 chooses non-volatile mirroring
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            store_enable_q <= 1'b0;
        end else if (gp_write && gp_index == GP_COORD_STORE) begin
            store_enable_q <= gp_value != 32'h0;
        end
    end

    // Main sequencer; restore at startup runs right after reset, before setting 84 can be on, so it reads nothing
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_RESTORE;
            cmd_ready <= 1'b0;
            hold_pc <= 1'b0;
            wait_left_q <= 32'h0;
            wait_timed_q <= 1'b0;
            wait_type_q <= 8'h0;
            walk_q <= 5'h1;
            walk_end_q <= 5'(LAST_COORD);
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    if (start && cmd.opcode == OP_WAIT) begin
                        state_q <= S_WAIT;
                        cmd_ready <= 1'b0;
                        hold_pc <= 1'b1;
                        wait_type_q <= cmd.typ;
                        wait_left_q <= tick_src;
                        wait_timed_q <= cmd.typ == WAIT_TICKS
                            || tick_src != 32'h0;
                    end else if (start && cmd.opcode == OP_SET_COORD
                                 && cmd.motor == MOTOR_STORE && cmd.value == 32'h0
                                 && cmd.typ <= LAST_COORD) begin
                        state_q <= S_STORE;
                        cmd_ready <= 1'b0;
                        walk_q <= (cmd.typ == 8'h0) ? 5'h1 : cmd.typ[4:0];
                        walk_end_q <= (cmd.typ == 8'h0) ? 5'(LAST_COORD)
                            : cmd.typ[4:0];
                    end else begin
                        cmd_ready <= 1'b1;
                    end
                end
                S_WAIT: begin
                    if (wait_type_q != WAIT_TICKS && wait_met) begin
                        state_q <= S_IDLE;
                        hold_pc <= 1'b0;
                        cmd_ready <= 1'b1;
                    end else if (wait_timed_q && (wait_left_q == 32'h0
                                 || (tick_q && wait_left_q == 32'h1))) begin
                        state_q <= S_IDLE;
                        hold_pc <= 1'b0;
                        cmd_ready <= 1'b1;
                    end else if (tick_q && wait_timed_q) begin
                        wait_left_q <= wait_left_q - 32'h1;
                    end
                end
                S_STORE: begin
                    walk_q <= walk_q + 5'h1;
                    if (walk_q == walk_end_q) begin
                        state_q <= S_IDLE;
                        cmd_ready <= 1'b1;
                    end
                end
                S_RESTORE: begin
                    // Nothing is restored unless setting 84 is on; default comes up off
                    if (!store_enable_q || walk_q > walk_end_q) begin
                        state_q <= S_IDLE;
                        cmd_ready <= 1'b1;
                    end else begin
                        state_q <= S_RESTORE_RD;
                    end
                end
                S_RESTORE_RD: begin
                    if (nv_rvalid) begin
                        walk_q <= walk_q + 5'h1;
                        state_q <= S_RESTORE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // Timeout flag: set wins over a clear in the same cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            timeout_error_flag <= 1'b0;
        end else if (state_q == S_WAIT && wait_type_q != WAIT_TICKS && !wait_met
                     && wait_timed_q && (wait_left_q == 32'h0
                     || (tick_q && wait_left_q == 32'h1))) begin
            timeout_error_flag <= 1'b1;
        end else if (start && cmd.opcode == OP_CLEAR_ERR) begin
            timeout_error_flag <= 1'b0;
        end
    end

    // Call stack, eight entries; a call past the depth is ignored
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sp_q <= 4'h0;
            pc_load <= 1'b0;
            pc_out <= 16'h0;
        end else begin
            pc_load <= 1'b0;
            if (start && standalone && cmd.opcode == OP_CALL && sp_q < 4'(STACK_DEPTH)) begin
                sp_q <= sp_q + 4'h1;
                pc_load <= 1'b1;
                pc_out <= cmd.value[15:0];
            end else if (start && standalone && cmd.opcode == OP_RETURN && sp_q != 4'h0) begin
                sp_q <= sp_q - 4'h1;
                pc_load <= 1'b1;
                pc_out <= stack_q[sp_q[2:0] - 3'h1];
            end else if (start && standalone && cmd.opcode == OP_JUMP_COND
                         && cmd.typ == COND_TIMEOUT && timeout_error_flag) begin
                pc_load <= 1'b1;
                pc_out <= cmd.value[15:0];
            end
        end
    end

    generate
        for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_stack
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    stack_q[i] <= 16'h0;
                end else if (start && standalone && cmd.opcode == OP_CALL
                             && sp_q == 4'(i)) begin
                    stack_q[i] <= pc_in; // caller supplies the return address
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            program_stop <= 1'b0;
        end else begin
            program_stop <= start && standalone && cmd.opcode == OP_STOP;
        end
    end

    // Coordinate array, one word per entry for this axis
    generate
        for (genvar i = 0; i < NUM_COORDS; i++) begin : g_coord
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    coord_q[i] <= 32'h0;
                end else if (start && cmd.opcode == OP_SET_COORD && cmd.motor == 8'h0
                             && cmd.typ == 8'(i)) begin
                    coord_q[i] <= cmd.value;
                end else if (i != 0 && state_q == S_RESTORE_RD && nv_rvalid
                             && walk_q == 5'(i)) begin
                    coord_q[i] <= nv_rdata;
                end
            end
        end
    endgenerate

    // Non-volatile port; single set-coordinate writes to entries 1 to 20 mirror when setting 84 is on
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            nv_we <= 1'b0;
            nv_re <= 1'b0;
            nv_addr <= 5'h0;
            nv_wdata <= 32'h0;
        end else begin
            nv_we <= 1'b0;
            nv_re <= 1'b0;
            if (state_q == S_STORE) begin
                nv_we <= 1'b1;
                nv_addr <= walk_q;
                nv_wdata <= coord_q[walk_q];
            end else if (state_q == S_RESTORE && store_enable_q && walk_q <= walk_end_q) begin
                nv_re <= 1'b1;
                nv_addr <= walk_q;
            end else if (start && cmd.opcode == OP_SET_COORD && cmd.motor == 8'h0
                         && store_enable_q && cmd.typ != 8'h0 && cmd.typ <= LAST_COORD) begin
                nv_we <= 1'b1;
                nv_addr <= cmd.typ[4:0];
                nv_wdata <= cmd.value;
            end
        end
    end

    // Get-coordinate: accumulator in standalone, reply in direct mode
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            accu_load <= 1'b0;
            accu_out <= 32'h0;
            reply_valid <= 1'b0;
            reply <= '0;
        end else begin
            accu_load <= 1'b0;
            reply_valid <= 1'b0;
            if (start && cmd.opcode == OP_GET_COORD) begin
                if (standalone) begin
                    accu_load <= cmd.typ <= LAST_COORD && cmd.motor == 8'h0;
                    accu_out <= (cmd.typ <= LAST_COORD) ? coord_q[cmd.typ[4:0]] : 32'h0;
                end else begin
                    reply_valid <= 1'b1;
                    reply.status <= (cmd.typ <= LAST_COORD && cmd.motor == 8'h0)
                        ? STATUS_OK : STATUS_BAD_CMD;
                    reply.value <= (cmd.typ <= LAST_COORD) ? coord_q[cmd.typ[4:0]] : 32'h0;
                end
            end
        end
    end
endmodule : flow_cmd_exec

/* File: flow_cmd_exec_chk.sv */
// Assertion checker for the flow command block, bound to its ports.
// Assumes one clock domain and the asynchronous low reset.
`timescale 1ns/1ps
module flow_cmd_exec_chk
    import flow_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire cmd_t cmd,
    input wire logic standalone,
    input wire axis_t axis,
    input wire logic cmd_ready,
    input wire logic pc_load,
    input wire logic [15:0] pc_out,
    input wire logic hold_pc,
    input wire logic program_stop,
    input wire logic accu_load,
    input wire logic reply_valid,
    input wire reply_t reply,
    input wire logic timeout_error_flag,
    input wire logic nv_we,
    input wire logic [4:0] nv_addr
);
    logic take;
    logic get_ok;
    logic wait_go;
    logic walk_go;
    logic [15:0] jump_addr;
    assign take = cmd_valid && cmd_ready;
    assign get_ok = take && cmd.opcode == OP_GET_COORD && cmd.motor == 8'h00
        && cmd.typ <= LAST_COORD;
    // Every wait holds at least one cycle: the exit test only runs once waiting
    assign wait_go = take && cmd.opcode == OP_WAIT;
    assign walk_go = take && cmd.opcode == OP_SET_COORD && cmd.motor == MOTOR_STORE
        && cmd.typ == 8'h00 && cmd.value == 32'h0;
    assign jump_addr = cmd.value[15:0];
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    chk_stop_pulse: assert property (
        take && cmd.opcode == OP_STOP && standalone |=> program_stop) else $error("no stop");
    chk_get_accu: assert property (
        get_ok && standalone |=> accu_load && !reply_valid) else $error("no accu load");
    chk_get_reply: assert property (
        get_ok && !standalone |=> reply_valid && reply.status == STATUS_OK && !accu_load)
        else $error("bad reply");
    chk_wait_hold: assert property (
        wait_go |=> hold_pc && !cmd_ready) else $error("wait not held");
    chk_flag_cause: assert property (
        $rose(timeout_error_flag) |-> $past(hold_pc)) else $error("flag without wait");
    chk_flag_keep: assert property (
        timeout_error_flag && !(take && cmd.opcode == OP_CLEAR_ERR) |=> timeout_error_flag)
        else $error("flag lost");
    chk_jump_flag: assert property (
        take && cmd.opcode == OP_JUMP_COND && cmd.typ == COND_TIMEOUT && timeout_error_flag
        |=> pc_load && pc_out == $past(jump_addr)) else $error("jump missed");
    chk_store_walk: assert property (
        walk_go |=> !cmd_ready ##1 nv_we && nv_addr == 5'h01) else $error("walk start");
    chk_nv_entry0: assert property (
        nv_we |-> nv_addr != 5'h00) else $error("entry zero stored");
endmodule : flow_cmd_exec_chk
bind flow_cmd_exec flow_cmd_exec_chk #(.TICK_CYCLES_P(TICK_CYCLES_P)) i_flow_cmd_exec_chk (
    .ref_clk, .rst_n, .cmd_valid, .cmd, .standalone, .axis, .cmd_ready, .pc_load, .pc_out,
    .hold_pc, .program_stop, .accu_load, .reply_valid, .reply, .timeout_error_flag, .nv_we,
    .nv_addr
);

/* File: flow_cmd_exec_tb.sv */
// Self-checking bench for the flow command block against a queue model.
// Assumes a 10-cycle tick and the store model on the far side.
`timescale 1ns/1ps
module flow_cmd_exec_tb
    import flow_pkg::*;
();
    localparam int T = 10;
    logic ref_clk, rst_n, cmd_valid, standalone, gp_write, slow, nv_rvalid, cmd_ready;
    logic pc_load, hold_pc, program_stop, accu_load, reply_valid, timeout_error_flag;
    logic nv_we, nv_re, ok;
    logic [7:0] gp_index;
    logic [4:0] nv_addr;
    logic [15:0] pc_in, pc_out, ret;
    logic [31:0] accu_in, gp_value, nv_rdata, nv_wdata, accu_out, v;
    cmd_t cmd;
    axis_t axis;
    reply_t reply;
    logic [15:0] stk [$];
    logic [31:0] coord [0:20];
    int err_count, total_checks, cycles, k;
    flow_cmd_exec #(.TICK_CYCLES_P(T)) i_flow_cmd_exec (
        .ref_clk, .rst_n, .cmd_valid, .cmd, .standalone, .pc_in, .accu_in, .axis, .gp_write,
        .gp_index, .gp_value, .nv_rdata, .nv_rvalid, .cmd_ready, .pc_load, .pc_out, .hold_pc,
        .program_stop, .accu_load, .accu_out, .reply_valid, .reply, .timeout_error_flag,
        .nv_we, .nv_addr, .nv_wdata, .nv_re
    );
    nv_store_model i_nv_store_model (
        .ref_clk, .rst_n, .slow, .nv_we, .nv_addr, .nv_wdata, .nv_re, .nv_rdata, .nv_rvalid
    );
    task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic give_verdict();
        if (err_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict
    // Waits for ready, holds the command one cycle, returns at the next falling edge
    task automatic send(input logic sa, input logic [7:0] op, input logic [7:0] ty,
                        input logic [7:0] mo, input logic [31:0] va);
        do @(negedge ref_clk); while (cmd_ready !== 1'b1 && cycles < 30000);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd <= '{op, ty, mo, va};
        standalone <= sa;
        pc_in <= 16'($urandom);
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        @(negedge ref_clk);
    endtask : send
    task automatic wait_end();
        k = 0;
        while (hold_pc === 1'b1 && k < 3000) begin
            @(negedge ref_clk);
            k++;
        end
    endtask : wait_end
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_count++;
            give_verdict();
        end
    end
    initial begin
        {rst_n, cmd_valid, standalone, gp_write, slow, pc_in, accu_in, gp_value} = '0;
        {gp_index, axis, cmd} = '0;
        void'($urandom(31));
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int j = 0; j <= 20; j++) begin
            v = $urandom;
            coord[j] = v;
            send(1'b0, OP_SET_COORD, 8'(j), 8'h00, v);
            check("nv_off", 0, nv_we);
            send(1'b0, OP_GET_COORD, 8'(j), 8'h00, 32'h0);
            check("get_flags", 2'h2, {reply_valid, accu_load});
            check("get_reply", {STATUS_OK, coord[j]}, reply);
            send(1'b1, OP_GET_COORD, 8'(j), 8'h00, 32'h0);
            check("get_prog", {1'b1, coord[j]}, {accu_load, accu_out});
        end
        for (int j = 0; j < 19; j++) begin
            if (j > 0 && j < 10) begin
                send(1'b1, OP_CALL, 8'h00, 8'h00, 32'(j));
                check("call", stk.size() < 8, pc_load);
                if (stk.size() < 8) stk.push_back(pc_in);
            end else begin
                send(1'b1, OP_RETURN, 8'h00, 8'h00, 32'h0);
                if (stk.size() > 0) begin
                    ret = stk.pop_back();
                    check("return", {1'b1, ret}, {pc_load, pc_out});
                end else begin
                    check("return_empty", 0, pc_load);
                end
            end
        end
        send(1'b1, OP_WAIT, WAIT_TICKS, 8'h00, 32'h2);
        wait_end();
        check("tick_wait", 1, k >= T - 2 && k <= 2 * T + 2);
        @(posedge ref_clk);
        accu_in <= 32'h3;
        send(1'b1, OP_WAIT, WAIT_TICKS, 8'h00, VALUE_ACCU);
        wait_end();
        check("accu_wait", 1, k >= 2 * T - 2 && k <= 3 * T + 2);
        for (int t = 1; t <= 4; t++) begin
            @(posedge ref_clk);
            axis <= axis_t'(4'($urandom) & ~(4'h1 << (4 - t)));
            send(1'b1, OP_WAIT, 8'(t), 8'h00, 32'h2);
            wait_end();
            ok = k >= T - 2 && k <= 2 * T + 2;
            check("timeout_len", 1, ok);
            check("flag_set", 1, timeout_error_flag);
            send(1'b1, OP_JUMP_COND, COND_TIMEOUT, 8'h00, 32'h77);
            check("jump_taken", 17'h10077, {pc_load, pc_out});
            send(1'b1, OP_CLEAR_ERR, 8'h00, 8'h00, 32'h0);
            send(1'b1, OP_JUMP_COND, COND_TIMEOUT, 8'h00, 32'h77);
            check("jump_clear", 0, {pc_load, timeout_error_flag});
            send(1'b1, OP_WAIT, 8'(t), 8'h00, 32'h0);
            repeat (3 * T) @(negedge ref_clk);
            check("no_timeout", 1, hold_pc);
            @(posedge ref_clk);
            axis <= axis_t'(4'h1 << (4 - t));
            wait_end();
            ok = k <= 3 && timeout_error_flag === 1'b0;
            check("cond_end", 1, ok);
        end
        send(1'b1, OP_STOP, 8'h00, 8'h00, 32'h0);
        check("stop", 1, program_stop);
        @(posedge ref_clk);
        {gp_write, gp_index, gp_value} <= {1'b1, GP_COORD_STORE, 32'h1};
        @(posedge ref_clk);
        gp_write <= 1'b0;
        v = $urandom;
        coord[3] = v;
        send(1'b0, OP_SET_COORD, 8'h03, 8'h00, v);
        check("nv_set", {1'b1, 5'h03, v}, {nv_we, nv_addr, nv_wdata});
        send(1'b0, OP_SET_COORD, 8'h00, 8'h00, v);
        coord[0] = v;
        check("nv_entry0", 0, nv_we);
        send(1'b0, OP_SET_COORD, 8'h05, MOTOR_STORE, 32'h0);
        // The store walk enters its own state first, so the write comes one cycle later
        @(negedge ref_clk);
        check("nv_one", {1'b1, 5'h05, coord[5]}, {nv_we, nv_addr, nv_wdata});
        send(1'b0, OP_SET_COORD, 8'h00, MOTOR_STORE, 32'h0);
        k = 0;
        repeat (30) begin
            k += (nv_we === 1'b1);
            @(negedge ref_clk);
        end
        check("walk_count", 20, k);
        check("no_read", 0, nv_re);
        for (int j = 1; j <= 20; j++) begin
            check("nv_copy", coord[j], i_nv_store_model.mem[j]);
        end
        give_verdict();
    end
endmodule : flow_cmd_exec_tb

/* File: flow_pkg.sv */
// Constants, types and command codes for the flow, wait and coordinate command block.
// Assumes a 50 MHz ref_clk; the program store and motion core sit outside.
package flow_pkg;
    localparam logic [7:0] OP_CALL = 8'h17;
    localparam logic [7:0] OP_RETURN = 8'h18;
    localparam logic [7:0] OP_WAIT = 8'h1B;
    localparam logic [7:0] OP_STOP = 8'h1C;
    localparam logic [7:0] OP_SET_COORD = 8'h1E;
    localparam logic [7:0] OP_GET_COORD = 8'h1F;
    localparam logic [7:0] OP_JUMP_COND = 8'h15;
    localparam logic [7:0] OP_CLEAR_ERR = 8'h24;
    localparam logic [7:0] COND_TIMEOUT = 8'h08;
    localparam logic [7:0] WAIT_TICKS = 8'h00;
    localparam logic [7:0] WAIT_POS = 8'h01;
    localparam logic [7:0] WAIT_HOME_SW = 8'h02;
    localparam logic [7:0] WAIT_END_SW = 8'h03;
    localparam logic [7:0] WAIT_HOMING = 8'h04;
    localparam logic [7:0] MOTOR_STORE = 8'hFF;
    localparam logic [7:0] STATUS_OK = 8'h64;
    localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
    localparam logic [7:0] GP_COORD_STORE = 8'h54;
    localparam logic [31:0] VALUE_ACCU = 32'hFFFF_FFFF;
    localparam int NUM_COORDS = 21;
    localparam logic [7:0] LAST_COORD = 8'h14;
    localparam int STACK_DEPTH = 8;
    localparam int CLK_HZ = 50_000_000;
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] typ;
        logic [7:0] motor;
        logic [31:0] value;
    } cmd_t;

    typedef struct packed {
        logic [7:0] status;
        logic [31:0] value;
    } reply_t;

    typedef struct packed {
        logic target_reached;
        logic home_switch;
        logic end_switch;
        logic homing_done;
    } axis_t;
endpackage : flow_pkg

/* File: nv_store_model.sv */
// Non-volatile coordinate store on the far side of the flow block.
// Assumes one request per cycle; reads answer after 1 or 4 cycles.
`timescale 1ns/1ps
module nv_store_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic nv_we,
    input wire logic [4:0] nv_addr,
    input wire logic [31:0] nv_wdata,
    input wire logic nv_re,
    output logic [31:0] nv_rdata,
    output logic nv_rvalid
);
    logic [31:0] mem [0:31];
    logic [2:0] delay_q;
    logic [4:0] addr_q;
    always_ff @(posedge ref_clk) begin
        if (nv_we) begin
            mem[nv_addr] <= nv_wdata;
        end
    end
    // Idle data toggles so a stale word never passes for an answer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            delay_q <= 3'h0;
            nv_rvalid <= 1'b0;
            nv_rdata <= 32'h0;
        end else begin
            nv_rvalid <= delay_q == 3'h1;
            nv_rdata <= (delay_q == 3'h1) ? mem[addr_q] : ~nv_rdata;
            if (nv_re) begin
                delay_q <= slow ? 3'h4 : 3'h1;
                addr_q <= nv_addr;
            end else if (delay_q != 3'h0) begin
                delay_q <= delay_q - 3'h1;
            end
        end
    end
endmodule : nv_store_model
